// [erpm_attr_counter.sv]
// Interval, error tally and degradation history for one attribute.
// Assumes op and err are synchronous single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module erpm_attr_counter
    import erpm_pkg::*;
#(
    parameter int CW = 16,
    parameter int HW = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Attribute link
    erpm_attr_if.cnt a
);
    logic [CW-1:0] ops_r;
    logic [CW-1:0] errs_r;
    logic [HW-1:0] hist_r;
    logic [CW-1:0] errs_nxt;
    logic expire;
    logic over;
    erpm_grade_t grade;

    always_comb begin
        errs_nxt = errs_r + ((a.op && a.err) ? CW'(1) : CW'(0));
        expire = a.enable && a.op && (ops_r + CW'(1) >= a.interval);
        // (R10) early bad grade
        over = a.enable && (errs_nxt > a.err_thresh);
        if (over) begin
            grade = ERPM_GRADE_BAD;
        end else if (expire) begin
            // (R11) good on expiry
            grade = ERPM_GRADE_GOOD;
        end else begin
            grade = ERPM_GRADE_NONE;
        end
    end

    // (R8) (R9) (R12) interval counting
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || grade != ERPM_GRADE_NONE) begin
            ops_r <= '0;
            errs_r <= '0;
        end else if (a.enable && a.op) begin
            ops_r <= ops_r + CW'(1);
            errs_r <= errs_nxt;
        end
    end

    // (R13) (R15) saturating history, floor zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            hist_r <= '0;
        end else if (grade == ERPM_GRADE_BAD && hist_r != '1) begin
            hist_r <= hist_r + HW'(1);
        end else if (grade == ERPM_GRADE_GOOD && hist_r != '0) begin
            hist_r <= hist_r - HW'(1);
        end
    end

    assign a.ops = ops_r;
    assign a.errs = errs_r;
    assign a.history = hist_r;
    // (R14) threshold reached
    assign a.fail = (a.pred_thresh != '0) && (hist_r >= a.pred_thresh);
    assign a.graded = grade != ERPM_GRADE_NONE;
    assign a.bad = grade == ERPM_GRADE_BAD;

    a_hist_floor: assert property ( // (R13)
        @(posedge i_ref_clk) disable iff (i_reset)
        grade == ERPM_GRADE_GOOD && hist_r == '0 |=> hist_r == '0)
        else $error("history went below zero");
    a_clear_after: assert property ( // (R12)
        @(posedge i_ref_clk) disable iff (i_reset)
        grade != ERPM_GRADE_NONE |=> ops_r == '0 && errs_r == '0)
        else $error("counters not cleared after grading");
    a_bad_up: assert property ( // (R13)
        @(posedge i_ref_clk) disable iff (i_reset)
        grade == ERPM_GRADE_BAD && hist_r != '1
        |=> hist_r == $past(hist_r) + HW'(1))
        else $error("history not incremented");
endmodule : erpm_attr_counter
`default_nettype wire

// [erpm_attr_if.sv]
// Per-attribute carrier between the top and the attribute counter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface erpm_attr_if #(parameter int CW = 16, parameter int HW = 8);
    logic op;
    logic err;
    logic enable;
    logic [CW-1:0] interval;
    logic [CW-1:0] err_thresh;
    logic [HW-1:0] pred_thresh;
    logic [CW-1:0] ops;
    logic [CW-1:0] errs;
    logic [HW-1:0] history;
    logic fail;
    logic graded;
    logic bad;
    modport ctl (output op, err, enable, interval, err_thresh, pred_thresh,
        input ops, errs, history, fail, graded, bad);
    modport cnt (input op, err, enable, interval, err_thresh, pred_thresh,
        output ops, errs, history, fail, graded, bad);
endinterface : erpm_attr_if
`default_nettype wire

// [erpm_defs.svh]
// Constants for the error rate predictive monitor.
// Assumes a 100 MHz reference clock; included by erpm_pkg and erpm_monitor.
// Summary of operation
// (R1) Save attribute data for later failure reconstruction
// (R2) Measure-and-save every two hours after bus idle
// (R3) Started measure-and-save cycle always runs to completion; the stall bound ends SAVE even without save done
// (R4) On-line-only mode stalls host at most 60 ms
// (R5) Fully enabled mode stalls host at most 450 ms
// (R6) Report sense code 01-5D00 on predictive failure
// (R7) Reported failure code persists across resets
// (R8) Count operations per attribute over programmed interval
// (R9) Count errors per attribute within current interval
// (R10) Errors above threshold before expiry: unacceptable
// (R11) Expiry without exceeding threshold: acceptable
// (R12) After grading clear both counters, restart interval
// (R13) History counts up bad, down good, floor zero
// (R14) History reaching predictive threshold signals failure
// (R15) Separate history counter for every attribute
// (R16) Disable flag suspends all monitoring functions
// (R17) On-line-only flag skips off-line measurement
// (R18) Rezero forces cycle and restarts two-hour timer
// (R19) Host reads time remaining until next measurement
// (R20) Interval and thresholds are configurable compare values
`ifndef ERPM_DEFS_SVH
`define ERPM_DEFS_SVH
`define ERPM_CLK_MHZ 100
`define ERPM_SCHED_S 7200
`define ERPM_SCHED_CYC (`ERPM_SCHED_S * 64'd100000000)
`define ERPM_ONLINE_MS 60
`define ERPM_FULL_MS 450
`define ERPM_IDLE_CYC 1000
`define ERPM_MS_CYC(ms) ((ms) * 1000 * `ERPM_CLK_MHZ)
`define ERPM_SENSE_KEY 8'h01
`define ERPM_SENSE_ASC 8'h5d
`define ERPM_SENSE_ASCQ 8'h00
`define ERPM_LOG_PAGE 8'h3e
`endif

// [erpm_host_model.sv]
// Far-side model that carries out the disc save for the monitor.
// Assumes save request is a level held until save done is seen.
`timescale 1ns/1ps
`default_nettype none
module erpm_host_model #(
    parameter int DLY = 5
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Save handshake
    input wire logic i_save_req,
    input wire logic i_slow,
    output logic o_save_done
);
    int cnt_r;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_save_req) begin
            cnt_r <= 0;
            o_save_done <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 1;
            // Slow mode never answers, so the stall bound must end it
            o_save_done <= !i_slow && cnt_r == DLY - 1;
        end
    end
endmodule : erpm_host_model
`default_nettype wire

// [erpm_monitor.sv]
// Top of the error rate predictive monitor with its scheduler.
// Assumes host strobes are synchronous; persistent store is outside.
`timescale 1ns/1ps
`default_nettype none
`include "erpm_defs.svh"
module erpm_monitor
    import erpm_pkg::*;
#(
    parameter int NA = 4,
    parameter int CW = 16,
    parameter int HW = 8,
    parameter longint SCHED_CYC = `ERPM_SCHED_CYC,
    parameter longint IDLE_CYC = `ERPM_IDLE_CYC,
    parameter longint ONLINE_CYC = `ERPM_MS_CYC(`ERPM_ONLINE_MS),
    parameter longint FULL_CYC = `ERPM_MS_CYC(`ERPM_FULL_MS)
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Mode flags
    input wire logic i_monitor_disable_flag,
    input wire logic i_online_only_flag,
    // Attribute events
    input wire logic [NA-1:0] i_op,
    input wire logic [NA-1:0] i_err,
    // Attribute configuration
    input wire logic [NA*CW-1:0] i_interval,
    input wire logic [NA*CW-1:0] i_err_thresh,
    input wire logic [NA*HW-1:0] i_pred_thresh,
    // Host bus
    input wire logic i_bus_busy,
    input wire logic i_rezero,
    input wire logic i_fail_restored,
    input wire logic i_fail_clear,
    // Measure-and-save
    input wire logic i_save_done,
    output logic o_host_stall,
    output logic o_save_req,
    output logic [NA*HW-1:0] o_save_history,
    output logic o_offline_measure,
    // Reporting
    output logic o_fail_pending,
    output logic [NA-1:0] o_fail_attr,
    output logic [23:0] o_sense_code,
    output logic [7:0] o_log_page,
    output logic [63:0] o_time_remaining
);
    logic enabled;
    logic [NA-1:0] fail_vec;
    logic [63:0] sched_r;
    logic [63:0] idle_r;
    logic [63:0] stall_r;
    logic [63:0] stall_max;
    logic due_r;
    logic fail_r;
    logic [NA-1:0] fail_attr_r;
    erpm_state_t state_r;

    // (R16) counting, snapshots, schedule and cycle start gated off when disabled
    assign enabled = !i_monitor_disable_flag;

    genvar g;
    generate
        for (g = 0; g < NA; g++) begin : g_attr
            erpm_attr_if #(.CW(CW), .HW(HW)) ai();
            assign ai.op = i_op[g];
            assign ai.err = i_err[g];
            assign ai.enable = enabled;
            assign ai.interval = i_interval[g*CW +: CW];
            assign ai.err_thresh = i_err_thresh[g*CW +: CW];
            assign ai.pred_thresh = i_pred_thresh[g*HW +: HW];
            assign fail_vec[g] = ai.fail;
            // (R20) per-attribute compare values
            erpm_attr_counter #(.CW(CW), .HW(HW)) u_cnt (
                .i_ref_clk(i_ref_clk),
                .i_reset(i_reset),
                .a(ai.cnt)
            );
            // One register per attribute, so each has a single writer
            logic [HW-1:0] snap_r;
            assign o_save_history[g*HW +: HW] = snap_r;
            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    snap_r <= '0;
                end else if (state_r == ERPM_IDLE && enabled) begin
                    // (R1) snapshot for the disc image
                    snap_r <= ai.history;
                end
            end
        end
    endgenerate

    // (R4) (R5) stall bound chosen by mode
    assign stall_max = i_online_only_flag ? ONLINE_CYC : FULL_CYC;

    // (R2) (R18) two-hour schedule
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sched_r <= SCHED_CYC;
            due_r <= 1'b0;
        end else if (enabled && i_rezero) begin
            sched_r <= SCHED_CYC;
            due_r <= 1'b1;
        end else if (state_r != ERPM_IDLE) begin
            due_r <= 1'b0;
        end else if (enabled && sched_r <= 64'd1) begin
            sched_r <= SCHED_CYC;
            due_r <= 1'b1;
        end else if (enabled) begin
            sched_r <= sched_r - 64'd1;
        end
    end

    // Bus idle time
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || i_bus_busy) begin
            idle_r <= '0;
        end else if (idle_r < IDLE_CYC) begin
            idle_r <= idle_r + 64'd1;
        end
    end

    // (R3) no host abort once started
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_r <= ERPM_IDLE;
            stall_r <= '0;
        end else begin
            case (state_r)
                ERPM_IDLE: begin
                    stall_r <= '0;
                    // (R18) rezero starts at once, even on a busy bus
                    if (enabled && (i_rezero
                            || (due_r && idle_r >= IDLE_CYC))) begin
                        // (R17) on-line-only skips measuring
                        state_r <= i_online_only_flag ? ERPM_SAVE
                                                      : ERPM_MEASURE;
                    end
                end
                ERPM_MEASURE: begin
                    stall_r <= stall_r + 64'd1;
                    if (stall_r + 64'd1 >= stall_max - 64'd1) begin
                        state_r <= ERPM_SAVE;
                    end
                end
                ERPM_SAVE: begin
                    stall_r <= stall_r + 64'd1;
                    // Time bound ends the stall even if the disc is late
                    if (i_save_done || stall_r + 64'd1 >= stall_max) begin
                        state_r <= ERPM_IDLE;
                    end
                end
                default: state_r <= ERPM_IDLE;
            endcase
        end
    end

    assign o_host_stall = state_r != ERPM_IDLE;
    assign o_save_req = state_r == ERPM_SAVE;
    assign o_offline_measure = state_r == ERPM_MEASURE;

    // (R6) (R7) sticky report; restored from persistent store
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fail_r <= 1'b0;
            fail_attr_r <= '0;
        end else if (i_fail_restored) begin
            fail_r <= 1'b1;
        end else if (enabled && |fail_vec) begin
            fail_r <= 1'b1;
            fail_attr_r <= fail_attr_r | fail_vec;
        end else if (i_fail_clear) begin
            fail_r <= 1'b0;
            fail_attr_r <= '0;
        end
    end

    assign o_fail_pending = fail_r;
    assign o_fail_attr = fail_attr_r;
    assign o_sense_code = fail_r ? {`ERPM_SENSE_KEY, `ERPM_SENSE_ASC,
                                    `ERPM_SENSE_ASCQ} : 24'h000000;
    // (R19) remaining time for the log page
    assign o_log_page = `ERPM_LOG_PAGE;
    assign o_time_remaining = sched_r;

    // Cycle steps
    sequence s_online_start;
        state_r == ERPM_IDLE && i_online_only_flag ##1 o_host_stall;
    endsequence

    sequence s_measure_end;
        state_r == ERPM_MEASURE ##1 state_r != ERPM_MEASURE;
    endsequence

    a_stall_bound: assert property ( // (R4)
        @(posedge i_ref_clk) disable iff (i_reset)
        o_host_stall |-> stall_r < stall_max)
        else $error("stall exceeded bound");
    a_fail_sticky: assert property ( // (R7)
        @(posedge i_ref_clk) disable iff (i_reset)
        fail_r && !i_fail_clear |=> fail_r)
        else $error("failure report lost");
    a_rezero_sched: assert property ( // (R18)
        @(posedge i_ref_clk) disable iff (i_reset)
        enabled && i_rezero |=> sched_r == SCHED_CYC && due_r)
        else $error("rezero did not restart schedule");
    a_disable_idle: assert property ( // (R16)
        @(posedge i_ref_clk) disable iff (i_reset)
        !enabled && state_r == ERPM_IDLE |=> state_r == ERPM_IDLE)
        else $error("cycle started while disabled");
    a_fail_report: assert property ( // (R6)
        @(posedge i_ref_clk) disable iff (i_reset)
        enabled && |fail_vec |=> o_sense_code == 24'h015d00)
        else $error("sense code not raised");
    a_rezero_start: assert property ( // (R18)
        @(posedge i_ref_clk) disable iff (i_reset)
        enabled && i_rezero && state_r == ERPM_IDLE |=> o_host_stall)
        else $error("rezero did not force a cycle");
    a_online_skip: assert property ( // (R17)
        @(posedge i_ref_clk) disable iff (i_reset)
        s_online_start |-> o_save_req)
        else $error("measure phase ran in on-line-only mode");
    a_measure_save: assert property ( // (R3)
        @(posedge i_ref_clk) disable iff (i_reset)
        s_measure_end |-> o_save_req)
        else $error("measure phase cut short");
    a_save_done: assert property ( // (R3)
        @(posedge i_ref_clk) disable iff (i_reset)
        o_save_req && i_save_done |=> !o_host_stall)
        else $error("stall kept after save done");
endmodule : erpm_monitor
`default_nettype wire

// [erpm_pkg.sv]
// Types for the error rate predictive monitor.
// Assumes erpm_defs.svh is on the include path.
`include "erpm_defs.svh"
package erpm_pkg;
    typedef enum logic [1:0] {
        ERPM_IDLE,
        ERPM_MEASURE,
        ERPM_SAVE
    } erpm_state_t;
    typedef enum logic [1:0] {
        ERPM_GRADE_NONE,
        ERPM_GRADE_GOOD,
        ERPM_GRADE_BAD
    } erpm_grade_t;
endpackage : erpm_pkg

// [test_error_rate_predictive_monitor.sv]
// Self-checking bench for the error rate predictive monitor.
// Assumes the host model answers save requests after a few cycles.
`timescale 1ns/1ps
`default_nettype none
module test_error_rate_predictive_monitor;
    typedef struct {logic [9:0] seq; int len; logic [1:0] mask;} erpm_row_t;
    localparam int SCH = 1000;
    localparam int ONL = 50;
    localparam int FULL = 200;
    logic clk = 0, rst = 1, dis = 0, onl = 0, busy = 1, rz = 0;
    logic fres = 0, fclr = 0, slow = 1, sdone, stall, sreq, offl, pend;
    logic [1:0] op = '0, err = '0, fattr;
    logic [31:0] ivl = 32'h00040004;
    logic [31:0] eth = 32'h00010001;
    logic [15:0] pth = 16'h0202;
    logic [15:0] hsave;
    logic [7:0] lpage;
    logic [23:0] sense;
    logic [63:0] trem;
    int n_mismatch = 0, cmp_count = 0, n;
    logic so, sr;
    // A history of two per attribute raises a failure; good intervals count it down
    erpm_row_t rows [6] = '{'{10'h011, 3, 2'b00}, '{10'h050, 4, 2'b01},
        '{10'h141, 5, 2'b01}, '{10'h00d, 2, 2'b00},
        '{10'h00f, 2, 2'b10}, '{10'h01d, 3, 2'b01}};
    erpm_monitor #(.NA(2), .SCHED_CYC(SCH), .IDLE_CYC(10), .ONLINE_CYC(ONL),
        .FULL_CYC(FULL)) dut_u (.i_ref_clk(clk),
        .i_reset(rst), .i_monitor_disable_flag(dis), .i_online_only_flag(onl),
        .i_op(op), .i_err(err), .i_interval(ivl),
        .i_err_thresh(eth), .i_pred_thresh(pth), .i_bus_busy(busy),
        .i_rezero(rz), .i_fail_restored(fres), .i_fail_clear(fclr),
        .i_save_done(sdone), .o_host_stall(stall), .o_save_req(sreq),
        .o_save_history(hsave), .o_offline_measure(offl),
        .o_fail_pending(pend), .o_fail_attr(fattr), .o_sense_code(sense),
        .o_log_page(lpage), .o_time_remaining(trem));
    erpm_host_model host_u (.i_ref_clk(clk), .i_reset(rst),
        .i_save_req(sreq), .i_slow(slow), .o_save_done(sdone));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic ev(input int a, input logic e, input logic o);
        op[a] = o;
        err[a] = e;
        tick(1);
        op = '0;
        err = '0;
        tick(1);
    endtask : ev
    // Bad: two errors with ops; good: stray error, one counted, four ops
    task automatic step(input logic [1:0] c);
        if (c[0]) begin
            repeat (2) ev(c[1], 1, 1);
        end else begin
            ev(c[1], 1, 0);
            ev(c[1], 1, 1);
            repeat (3) ev(c[1], 0, 1);
        end
    endtask : step
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
        tick(1);
    endtask : pulse
    task automatic do_reset;
        rst = 1;
        tick(20);
        rst = 0;
    endtask : do_reset
    task automatic run_cycle;
        int w;
        w = 0;
        n = 0;
        so = 0;
        sr = 0;
        while (stall !== 1'b1 && w < 50) begin
            tick(1);
            w++;
        end
        if (stall !== 1'b1) begin
            n_mismatch++;
        end
        // Host traffic during a cycle must not cut it short
        busy = 1;
        while (stall === 1'b1 && n < 1000) begin
            so |= offl;
            sr |= sreq;
            tick(1);
            n++;
        end
        if (stall === 1'b1) begin
            n_mismatch++;
        end
    endtask : run_cycle
    initial begin
        tick(1);
        do_reset();
        check(stall, 0);
        check(sense, 0);
        check(lpage, 8'h3e);
        check(trem, SCH);
        foreach (rows[r]) begin
            do_reset();
            for (int i = 0; i < rows[r].len; i++) step(rows[r].seq[2*i+:2]);
            tick(3);
            check(fattr, rows[r].mask);
            check(pend, |rows[r].mask);
            check(sense, |rows[r].mask ? 24'h015d00 : 24'h0);
        end
        // Attribute 0 gets zero error and unit predictive thresholds
        do_reset();
        eth = 32'h00010000;
        pth = 16'h0201;
        ev(0, 1, 1);
        tick(3);
        check(fattr, 2'b01);
        check(hsave, 16'h0001);
        eth = 32'h00010001;
        pth = 16'h0202;
        do_reset();
        check(pend, 0);
        pulse(fres);
        check(pend, 1);
        pulse(fclr);
        check(pend, 0);
        dis = 1;
        repeat (2) step(2'b01);
        pulse(rz);
        tick(5);
        check(pend, 0);
        check(stall, 0);
        dis = 0;
        onl = 1;
        pulse(rz);
        run_cycle();
        check(so, 0);
        check(n + 1 <= ONL, 1);
        check(trem > SCH - 100, 1);
        slow = 0;
        pulse(rz);
        run_cycle();
        check(sr, 1);
        check(n + 1 < ONL, 1);
        onl = 0;
        pulse(rz);
        run_cycle();
        check(so, 1);
        check(n + 1 <= FULL, 1);
        do_reset();
        tick(SCH + 100);
        check(stall, 0);
        busy = 0;
        run_cycle();
        check(sr, 1);
        check(n >= FULL - 1, 1);
        end_of_test();
    end
    initial begin
        #900000;
        n_mismatch++;
        end_of_test();
    end
endmodule : test_error_rate_predictive_monitor
`default_nettype wire
